//--- din_sync.sv
// Purpose: two-stage synchroniser for one input per bit
// Assumes: single clock domain
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module din_sync #(
   parameter int unsigned W = 3
) (
   input  wire logic         clk,     // control clock
   input  wire logic         arst_n,  // async reset
   input  wire logic [W-1:0] din,     // raw inputs
   output logic      [W-1:0] dout     // synchronised
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1Reg;
         logic s2Reg;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               s1Reg <= 1'b0;
               s2Reg <= 1'b0;
            end else begin
               s1Reg <= din[i];
               s2Reg <= s1Reg;
            end
         end
         assign dout[i] = s2Reg;
      end
   endgenerate
endmodule
`default_nettype wire

//--- ext_source_model.sv
// Purpose: interlock contact, trigger source and sync reference
// Assumes: commanded by the bench
// Notes:   sync reference stands still while off
`timescale 1ns/100ps
`default_nettype none
module ext_source_model (
   input  wire logic clk,                  // clock
   input  wire logic closeCmd,             // close contact
   input  wire logic fireCmd,              // fire trigger
   input  wire logic syncOn,               // run sync ref
   output logic      interlock_contact_in, // contact
   output logic      transient_start_in,   // trigger
   output logic      sync_ref_in           // sync ref
);
   int tCnt = 0;
   int sCnt = 0;
   assign interlock_contact_in = closeCmd;
   // six-cycle high so the synchroniser surely sees it
   assign transient_start_in = tCnt != 0;
   assign sync_ref_in = syncOn && sCnt < 10;
   always @(posedge clk) begin
      tCnt <= fireCmd ? 6 : (tCnt != 0 ? tCnt - 1 : 0);
      sCnt <= syncOn ? (sCnt + 1) % 20 : 0;
   end
endmodule
`default_nettype wire

//--- inhibit_trig_pkg.sv
// Purpose: constants and types for the output-inhibit and trigger block
// Assumes: 100 MHz control clock
// Notes:   times in their own unit, cycle counts derived here
package inhibit_trig_pkg;
   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned SYNC_STAGES      = 2;
   // sync reference band, rising edges only
   localparam int unsigned SYNC_MIN_HZ      = 15;
   localparam int unsigned SYNC_MAX_HZ      = 1200;
   // shortest valid period rounds down, longest rounds up
   localparam int unsigned SYNC_MIN_CYC     = CLK_HZ / SYNC_MAX_HZ;
   localparam int unsigned SYNC_MAX_CYC     = (CLK_HZ + SYNC_MIN_HZ - 1) / SYNC_MIN_HZ;
   localparam int unsigned PER_W            = 24;
   // countdown warning before a remote enable
   localparam int unsigned WARN_MS          = 3000;
   localparam int unsigned WARN_CYC         = WARN_MS * (CLK_HZ / 1000);
   localparam int unsigned WARN_W           = 29;
   // reset values of the settings
   localparam logic        AUTO_RST         = 1'b1;
   localparam logic        RENA_RST         = 1'b0;
   localparam logic [1:0]  MODE_RST         = 2'h0;

   typedef enum logic [1:0] {
      CM_DISABLED = 2'h0,
      CM_INHIBIT  = 2'h1,
      CM_REMOTE   = 2'h2
   } contact_mode_t;

   // gray along idle -> armed -> running
   typedef enum logic [1:0] {
      TR_IDLE  = 2'h0,
      TR_ARMED = 2'h1,
      TR_RUN   = 2'h3
   } tr_state_t;
endpackage

//--- remote_inhibit_trigger_ctrl.sv
// Purpose: output-enable gating, transient trigger and sync edge front end
// Assumes: control inputs synchronous-ish; contact, trigger and sync ref synchronised here anyway
// Notes:   warning time is a parameter so simulation can shorten it
`timescale 1ns/100ps
`default_nettype none
module remote_inhibit_trigger_ctrl
   import inhibit_trig_pkg::*;
#(
   parameter int unsigned WARN_CYCLES = WARN_CYC
) (
   input  wire logic        clk,                  // 100 MHz clock
   input  wire logic        arst_n,               // async reset
   input  wire logic        interlock_contact_in, // contact closed = 1
   input  wire logic        transient_start_in,   // trigger input
   input  wire logic        sync_ref_in,          // phase sync reference
   input  wire logic [1:0]  contactModeSel,       // contact mode
   input  wire logic        autoWr,               // write auto setting
   input  wire logic        autoWrData,           // value for auto
   input  wire logic        renaWr,               // write enable-mode setting
   input  wire logic        renaWrData,           // value for enable mode
   input  wire logic        sanitize,             // restore settings
   input  wire logic        outOnReq,             // panel/remote enable pulse
   input  wire logic        outOffReq,            // panel/remote disable pulse
   input  wire logic        faultClr,             // clear fault pulse
   input  wire logic        trigModeOn,           // trigger input mode
   input  wire logic        progLaunch,           // transient launched pulse
   input  wire logic        progAbort,            // transient aborted pulse
   input  wire logic        progDone,             // transient finished pulse
   input  wire logic        syncEnable,           // phase sync in use
   output logic             outEnable,            // power output on
   output logic             faultOut,             // interlock fault
   output logic             warnActive,           // countdown warning
   output logic             autoSetting,          // auto setting
   output logic             renaSetting,          // enable-mode setting
   output logic             progRunning,          // status running
   output logic             progStarted,          // progress may advance
   output logic             progStartPulse,       // program starts now
   output logic             phaseALockPulse,      // phase A realign strobe
   output logic [PER_W-1:0] syncPeriod,           // last measured period, in or out of band
   output logic             syncValid             // period in band
);
   logic [2:0] inSync;
   logic       ciPrevReg, trigPrevReg, srPrevReg;
   logic       ci, ciRise, ciFall, trigRise, srRise;
   logic       pwrUpReg, pwrUpNext;

   din_sync #(.W(3)) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .din    ({sync_ref_in, transient_start_in, interlock_contact_in}),
      .dout   (inSync)
   );

   assign ci     = inSync[0];
   assign ciRise = ci & ~ciPrevReg;
   assign ciFall = ~ci & ciPrevReg;
   assign trigRise = inSync[1] & ~trigPrevReg;
   assign srRise = inSync[2] & ~srPrevReg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ciPrevReg <= 1'b0;
         trigPrevReg <= 1'b0;
         srPrevReg <= 1'b0;
         pwrUpReg  <= 1'b1;
      end else begin
         ciPrevReg <= ci;
         trigPrevReg <= inSync[1];
         srPrevReg <= inSync[2];
         pwrUpReg  <= pwrUpNext;
      end
   end

   // settings
   logic autoReg, autoNext, renaReg, renaNext;
   always_comb begin
      autoNext = autoReg;
      renaNext = renaReg;
      if (autoWr)
         autoNext = autoWrData;
      if (renaWr)
         renaNext = renaWrData;
      if (sanitize) begin
         autoNext = AUTO_RST;
         renaNext = RENA_RST;
      end
   end

   // output enable, fault and warning countdown
   contact_mode_t     mode;
   logic              enReg, enNext, fltReg, fltNext, warnReg, warnNext;
   logic [WARN_W-1:0] wcntReg, wcntNext;
   logic              remoteOnEvt;

   always_comb begin
      case (contactModeSel)
         2'h1:    mode = CM_INHIBIT;
         2'h2:    mode = CM_REMOTE;
         default: mode = CM_DISABLED;
      endcase
   end

   // power-up check covers only the first cycle after reset, while the synchroniser still outputs 0
   assign pwrUpNext   = 1'b0;
   assign remoteOnEvt = (mode == CM_REMOTE) &&
                        ((autoReg && ((pwrUpReg && ci) || ciRise)) ||
                         (!autoReg && ciRise));

   always_comb begin
      enNext   = enReg;
      fltNext  = fltReg;
      warnNext = warnReg;
      wcntNext = wcntReg;
      if (faultClr)
         fltNext = 1'b0;
      case (mode)
         CM_INHIBIT: begin
            if (outOnReq && ci && !fltReg)
               enNext = 1'b1;
            if (enReg && !ci) begin
               enNext  = 1'b0;
               fltNext = 1'b1;
            end
            warnNext = 1'b0;
         end
         CM_REMOTE: begin
            if (remoteOnEvt && !enReg && !warnReg) begin
               warnNext = 1'b1;
               wcntNext = WARN_W'(WARN_CYCLES - 1);
            end else if (warnReg) begin
               if (!ci) begin
                  warnNext = 1'b0;
               end else if (wcntReg == '0) begin
                  warnNext = 1'b0;
                  enNext   = 1'b1;
               end else begin
                  wcntNext = wcntReg - 1'b1;
               end
            end
            if (ciFall && !autoReg) begin
               enNext   = 1'b0;
               warnNext = 1'b0;
            end
            if (outOnReq)
               enNext = 1'b1;
         end
         default: begin
            if (outOnReq)
               enNext = 1'b1;
            warnNext = 1'b0;
         end
      endcase
      if (outOffReq) begin
         enNext   = 1'b0;
         warnNext = 1'b0;
      end
   end

   // transient trigger
   tr_state_t trReg, trNext;
   logic      startNext;
   logic      runNext;
   logic      stNext;
   always_comb begin
      trNext    = trReg;
      startNext = 1'b0;
      case (trReg)
         TR_IDLE: begin
            if (progLaunch)
               trNext = trigModeOn ? TR_ARMED : TR_RUN;
            startNext = progLaunch && !trigModeOn;
         end
         TR_ARMED: begin
            if (progAbort || !trigModeOn) begin
               trNext = TR_IDLE;
            end else if (trigRise) begin
               trNext    = TR_RUN;
               startNext = 1'b1;
            end
         end
         TR_RUN: begin
            if (progAbort || progDone)
               trNext = TR_IDLE;
         end
         default: trNext = TR_IDLE;
      endcase
      // status follows the next state so it leaves flops with the state
      runNext = (trNext != TR_IDLE);
      stNext  = (trNext == TR_RUN);
   end

   // sync reference period measurement
   logic [PER_W-1:0] pcntReg, pcntNext, perReg, perNext;
   logic             svReg, svNext, lockNext;
   always_comb begin
      pcntNext = pcntReg;
      perNext  = perReg;
      svNext   = svReg;
      lockNext = 1'b0;
      if (!syncEnable) begin
         pcntNext = '0;
         svNext   = 1'b0;
      end else if (srRise) begin
         pcntNext = '0;
         perNext  = pcntReg;
         svNext   = (pcntReg >= PER_W'(SYNC_MIN_CYC)) &&
                    (pcntReg <= PER_W'(SYNC_MAX_CYC));
         // realign only if the previous period was in band (svReg), not the one just measured
         lockNext = svReg;
      end else if (pcntReg != '1) begin
         pcntNext = pcntReg + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         autoReg  <= AUTO_RST;
         renaReg  <= RENA_RST;
         enReg    <= 1'b0;
         fltReg   <= 1'b0;
         warnReg  <= 1'b0;
         wcntReg  <= '0;
         trReg    <= TR_IDLE;
         pcntReg  <= '0;
         perReg   <= '0;
         svReg    <= 1'b0;
         progStartPulse  <= 1'b0;
         phaseALockPulse <= 1'b0;
         progRunning     <= 1'b0;
         progStarted     <= 1'b0;
      end else begin
         autoReg  <= autoNext;
         renaReg  <= renaNext;
         enReg    <= enNext;
         fltReg   <= fltNext;
         warnReg  <= warnNext;
         wcntReg  <= wcntNext;
         trReg    <= trNext;
         pcntReg  <= pcntNext;
         perReg   <= perNext;
         svReg    <= svNext;
         progStartPulse  <= startNext;
         phaseALockPulse <= lockNext;
         progRunning     <= runNext;
         progStarted     <= stNext;
      end
   end

   assign outEnable   = enReg;
   assign faultOut    = fltReg;
   assign warnActive  = warnReg;
   assign autoSetting = autoReg;
   assign renaSetting = renaReg;
   assign syncPeriod  = perReg;
   assign syncValid   = svReg;
endmodule
`default_nettype wire

//--- remote_inhibit_trigger_ctrl_assertions.sv
// Purpose: port-level checks of output gating and trigger
// Assumes: one clock, async active-low reset
// Notes:   bound onto the top module
`timescale 1ns/100ps
`default_nettype none
module rit_checker (
   input wire logic       clk,             // clock
   input wire logic       arst_n,          // reset
   input wire logic [1:0] contactModeSel,  // mode
   input wire logic       autoWr,          // auto write
   input wire logic       autoWrData,      // auto data
   input wire logic       sanitize,        // restore
   input wire logic       progAbort,       // abort
   input wire logic       progLaunch,      // launch
   input wire logic       outEnable,       // output on
   input wire logic       faultOut,        // fault
   input wire logic       warnActive,      // warning
   input wire logic       autoSetting,     // auto
   input wire logic       renaSetting,     // enable mode
   input wire logic       progRunning,     // running
   input wire logic       progStarted,     // started
   input wire logic       progStartPulse,  // start
   input wire logic       phaseALockPulse, // lock
   input wire logic       syncValid        // in band
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_fault_only_inhibit: assert property (
      $rose(faultOut) |-> $past(contactModeSel) == 2'h1)
      else $error("fault outside inhibit mode");
   a_fault_drops_out: assert property (
      $rose(faultOut) |-> !outEnable && $past(outEnable))
      else $error("fault without output drop");
   a_warn_holds_off: assert property ($rose(warnActive) |-> !outEnable [*8])
      else $error("output on during warning");
   a_start_from_run: assert property (
      progStartPulse |-> progStarted && ($past(progRunning) || $past(progLaunch)))
      else $error("start without launch");
   a_start_marks: assert property ($rose(progStarted) |-> progStartPulse)
      else $error("progress left zero without start");
   a_abort_clears: assert property (progAbort |=> !progRunning && !progStarted)
      else $error("abort left program pending");
   a_sanitize_restores: assert property (sanitize |=> autoSetting && !renaSetting)
      else $error("sanitize values wrong");
   a_auto_write: assert property (
      autoWr && !sanitize |=> autoSetting == $past(autoWrData))
      else $error("auto setting not written");
   a_lock_needs_valid: assert property (phaseALockPulse |-> $past(syncValid))
      else $error("lock pulse out of band");
endmodule
bind remote_inhibit_trigger_ctrl rit_checker u_rit_checker (.clk, .arst_n, .contactModeSel,
   .autoWr, .autoWrData, .sanitize, .progAbort, .progLaunch, .outEnable, .faultOut,
   .warnActive, .autoSetting, .renaSetting, .progRunning, .progStarted, .progStartPulse,
   .phaseALockPulse, .syncValid);
`default_nettype wire

//--- remote_inhibit_trigger_ctrl_tb_top.sv
// Purpose: self-checking bench for output gating and trigger
// Assumes: warning shortened to 10 cycles
// Notes:   snapshot is period, then bits oe,fault,warn,run,started,auto,rena,valid
`timescale 1ns/100ps
`default_nettype none
module remote_inhibit_trigger_ctrl_tb_top;
   import inhibit_trig_pkg::*;
   `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
   logic clk = 0, arst_n = 0, closeCmd = 0, syncOn = 0, autoWrData = 0, renaWrData = 0;
   logic trigModeOn = 0, syncEnable = 0;
   logic [1:0] contactModeSel = 2'h0;
   logic [9:0] pul = 10'h000;
   logic interlock_contact_in, transient_start_in, sync_ref_in, outEnable, faultOut;
   logic warnActive, autoSetting, renaSetting, progRunning, progStarted, syncValid;
   logic [PER_W-1:0] syncPeriod;
   logic [31:0] snap;
   logic [31:0] q[$];
   logic [31:0] rs = 32'h3fba;
   int n_mismatch = 0;
   int total_checks = 0;
   event obs;
   always #5 clk = ~clk;
   assign snap = {syncPeriod, outEnable, faultOut, warnActive, progRunning, progStarted,
                  autoSetting, renaSetting, syncValid};
   remote_inhibit_trigger_ctrl #(.WARN_CYCLES(10)) u_remote_inhibit_trigger_ctrl (.clk,
      .arst_n, .interlock_contact_in, .transient_start_in, .sync_ref_in, .contactModeSel,
      .autoWr(pul[0]), .autoWrData, .renaWr(pul[1]), .renaWrData, .sanitize(pul[2]),
      .outOnReq(pul[3]), .outOffReq(pul[4]), .faultClr(pul[5]), .trigModeOn,
      .progLaunch(pul[6]), .progAbort(pul[7]), .progDone(pul[8]), .syncEnable, .outEnable,
      .faultOut, .warnActive, .autoSetting, .renaSetting, .progRunning, .progStarted,
      .progStartPulse(), .phaseALockPulse(), .syncPeriod, .syncValid);
   ext_source_model u_ext_source_model (.clk, .closeCmd, .fireCmd(pul[9]), .syncOn,
      .interlock_contact_in, .transient_start_in, .sync_ref_in);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input logic [9:0] m);
      pul <= m;
      @(posedge clk);
      pul <= 10'h000;
   endtask
   // takes an edge so that pulses never meet in one time step
   task automatic chk(input logic [31:0] e);
      q.push_back(e);
      ->obs;
      @(posedge clk);
   endtask
   // polls off the edge so a launching flop is never raced
   task automatic wait_on;
      int k;
      for (k = 0; k < 40; k++) begin
         @(negedge clk);
         if (outEnable === 1'b1)
            break;
      end
      @(posedge clk);
      if (k == 40)
         n_mismatch++;
   endtask
   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(obs) begin
      logic [31:0] expVal;
      #1;
      // popped once, so a mismatch report cannot eat the next note
      expVal = q.pop_front();
      `CHK(snap, expVal)
   end
   initial begin
      int i;
      logic [31:0] rb;
      cyc(3);
      arst_n <= 1'b1;
      chk(32'h04);
      for (i = 0; i < 2; i++) begin
         contactModeSel <= i ? 2'h3 : 2'h0;
         pulse(10'h008);
         chk(32'h84);
         pulse(10'h010);
         chk(32'h04);
      end
      $display("test disabled done");
      contactModeSel <= 2'h1;
      pulse(10'h008);
      chk(32'h04);
      closeCmd <= 1'b1;
      cyc(6);
      chk(32'h04);
      pulse(10'h008);
      chk(32'h84);
      closeCmd <= 1'b0;
      cyc(6);
      chk(32'h44);
      pulse(10'h020);
      chk(32'h04);
      $display("test inhibit done");
      rs = xs(rs);
      renaWrData <= rs[0];
      pulse(10'h003);
      rb = {30'h0, rs[0], 1'b0};
      chk(rb);
      contactModeSel <= 2'h2;
      closeCmd <= 1'b1;
      cyc(6);
      chk(32'h20 | rb);
      wait_on();
      chk(32'h80 | rb);
      closeCmd <= 1'b0;
      cyc(6);
      chk(rb);
      renaWrData <= 1'b1;
      pulse(10'h007);
      chk(32'h04);
      // second reset with the contact held closed: auto setting stays on, output turns on after the warning
      arst_n <= 1'b0;
      closeCmd <= 1'b1;
      cyc(3);
      arst_n <= 1'b1;
      chk(32'h04);
      cyc(5);
      chk(32'h24);
      wait_on();
      chk(32'h84);
      closeCmd <= 1'b0;
      cyc(6);
      chk(32'h84);
      pulse(10'h010);
      chk(32'h04);
      $display("test remote enable done");
      contactModeSel <= 2'h0;
      trigModeOn <= 1'b1;
      pulse(10'h200);
      cyc(8);
      chk(32'h04);
      pulse(10'h040);
      chk(32'h14);
      cyc(4);
      chk(32'h14);
      pulse(10'h200);
      cyc(5);
      chk(32'h1c);
      pulse(10'h100);
      chk(32'h04);
      pulse(10'h040);
      chk(32'h14);
      pulse(10'h080);
      chk(32'h04);
      pulse(10'h040);
      chk(32'h14);
      trigModeOn <= 1'b0;
      cyc(1);
      chk(32'h04);
      pulse(10'h040);
      chk(32'h1c);
      pulse(10'h100);
      chk(32'h04);
      $display("test trigger done");
      syncEnable <= 1'b1;
      syncOn <= 1'b1;
      cyc(100);
      // model reference repeats every 20 clocks, far below the valid band
      chk({24'h13, 8'h04});
      $display("test sync done");
      end_of_test();
   end
endmodule
`default_nettype wire
